// *** verilog/mbs_pkg.sv ***
package mbs_pkg;
	// Terminal count, parameter count and parameter word width.
	localparam int NTERM = 5;
	localparam int NPAR = 6;
	localparam int PW = 16;
	localparam int AW = 8;

	// Input terminal function codes.
	localparam logic [7:0] FN_SECOND_MOTOR = 8'h08;
	localparam logic [7:0] FN_LIVE_SWITCH = 8'h35;
	localparam logic [7:0] FN_RST = 8'h00;

	// Parameters that the live switch may swap, one bit per index.
	localparam logic [NPAR-1:0] LIVE_MASK = 6'h1f;
	localparam logic [PW-1:0] PAR_RST = 16'h0000;

	// Register byte addresses.
	localparam logic [AW-1:0] ADDR_TERM = 8'h00;
	localparam logic [AW-1:0] ADDR_STATUS = 8'h14;
	localparam logic [AW-1:0] ADDR_BANK1 = 8'h20;
	localparam logic [AW-1:0] ADDR_BANK2 = 8'h40;

	// Status register bit positions.
	localparam int ST_ACTIVE = 0;
	localparam int ST_LIVE = 1;
	localparam int ST_STOPPED = 2;
	localparam int ST_TERM = 8;

	// Bus response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Active parameter set handed to the frequency generator.
	typedef struct packed {
		logic [PW-1:0] baseFreq;
		logic [PW-1:0] accelTimeTwo;
		logic [PW-1:0] boostLevel;
		logic [PW-1:0] multispeedZeroFreq;
		logic [PW-1:0] decelTimeOne;
		logic [PW-1:0] accelTimeOne;
	} mbs_param_s;
endpackage

// *** verilog/mbs_bank_select.sv ***
`timescale 1ns/1ps
// Functional notes
// - Second-motor terminal active selects second bank.
// - Terminal inactive returns to first bank.
// - Selection change while running waits for stop.
// - Live switch terminal swaps banks immediately.
// - Live switch swaps only ramp, speed, boost.
// - Any of five terminals takes either function.
module mbs_bank_select #(
	parameter int NTERM = mbs_pkg::NTERM
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic [NTERM-1:0] termIn,
	input wire logic driveStopped,
	input wire logic [mbs_pkg::AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [mbs_pkg::AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output mbs_pkg::mbs_param_s activeParam,
	output logic activeBank,
	output logic liveBank
);
	localparam int PW = mbs_pkg::PW;
	localparam int NPAR = mbs_pkg::NPAR;
	localparam int AW = mbs_pkg::AW;
	localparam int BANKGAP = int'(mbs_pkg::ADDR_BANK2) -
		int'(mbs_pkg::ADDR_BANK1);

	// The terminal count is capped by the register map: the fifth
	// function word sits just below the status word, so a sixth
	// terminal would collide with it.
	if (NTERM < 1 || NTERM > 5) begin : gBadTerm
		$error("NTERM must lie between 1 and 5");
	end

	// The first bank must end before the second one starts, or a write
	// meant for one bank would land in both decoders at once.
	if (4 * NPAR > BANKGAP) begin : gBadPar
		$error("Parameter banks overlap in the register map");
	end

	// A parameter word is carried in the low bits of one bus word.
	if (PW < 1 || PW > 32) begin : gBadWidth
		$error("Parameter word does not fit a bus word");
	end

	// Register index inside a window, or -1 when outside it. Misaligned
	// byte addresses fall outside every window, so a stray access can
	// never touch two neighbouring words.
	function automatic int winIndex(input logic [AW-1:0] a,
		input logic [AW-1:0] base, input int n);
		int idx;
		idx = -1;
		if (a >= base && a < base + AW'(4 * n) && a[1:0] == 2'h0) begin
			idx = int'((a - base) >> 2);
		end
		return idx;
	endfunction

	// Byte-lane merge of write data into an old word. Lanes above a
	// narrow register are merged too and then simply dropped.
	function automatic logic [31:0] laneMerge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Function code per terminal, both parameter banks, the stop-gated
	// select and the registered parameter set handed downstream.
	logic [7:0] termFunc_r [NTERM];
	logic [7:0] termFunc_nxt [NTERM];
	logic [PW-1:0] bank_r [2][NPAR];
	logic [PW-1:0] bank_nxt [2][NPAR];
	logic stopSel_r;
	logic stopSel_nxt;
	logic [NPAR*PW-1:0] outVec_r;
	logic [NPAR*PW-1:0] outVec_nxt;

	// Bus response state.
	logic bvalid_r;
	logic bvalid_nxt;
	logic [1:0] bresp_r;
	logic [1:0] bresp_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [1:0] rresp_r;
	logic [1:0] rresp_nxt;

	// Terminal decode and handshake strobes.
	logic [NTERM-1:0] setHit;
	logic [NTERM-1:0] liveHit;
	logic setReq;
	logic liveReq;
	logic wrGo;
	logic rdGo;

	// Each terminal is checked against both functions. A terminal whose
	// code is neither function is simply ignored here, since the other
	// terminal functions live in other blocks.
	for (genvar t = 0; t < NTERM; t++) begin : gTerm
		assign setHit[t] = termIn[t] &&
			termFunc_r[t] == mbs_pkg::FN_SECOND_MOTOR;
		assign liveHit[t] = termIn[t] &&
			termFunc_r[t] == mbs_pkg::FN_LIVE_SWITCH;
	end
	assign setReq = |setHit;
	assign liveReq = |liveHit;

	// Address and data are taken together; a held response blocks more.
	// Taking both at one edge avoids buffering a lone address or data
	// beat, at the cost of one write every second cycle at best.
	assign wrGo = clkEn && s_axi_awvalid && s_axi_wvalid && !bvalid_r;
	assign rdGo = clkEn && s_axi_arvalid && !rvalid_r;
	assign s_axi_awready = wrGo;
	assign s_axi_wready = wrGo;
	assign s_axi_arready = rdGo;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// Bank selection and the registered parameter set. The stop-gated
	// select only follows the terminal while the drive reports stopped,
	// so a change made at speed never retunes the motor model mid-run.
	// The live subset may move at speed; the remaining fields always
	// follow the stop-gated select.
	always_comb begin
		logic liveSel;
		liveSel = 1'b0;
		stopSel_nxt = stopSel_r;
		outVec_nxt = outVec_r;
		if (clkEn) begin
			if (driveStopped) begin
				stopSel_nxt = setReq;
			end
			// Live switch acts at once and also honours the stopped select.
			liveSel = liveReq | stopSel_r;
			for (int p = 0; p < NPAR; p++) begin
				if (mbs_pkg::LIVE_MASK[p]) begin
					outVec_nxt[p*PW +: PW] =
						bank_r[liveSel][p];
				end else begin
					outVec_nxt[p*PW +: PW] =
						bank_r[stopSel_r][p];
				end
			end
		end
	end

	// Selection registers; reset starts on the first bank with every
	// field of the parameter set cleared.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stopSel_r <= 1'b0;
			outVec_r <= '0;
		end else begin
			stopSel_r <= stopSel_nxt;
			outVec_r <= outVec_nxt;
		end
	end

	// Parameter set and bank indications. The live indication is a
	// plain decode, so it leads the registered parameter set by a cycle.
	assign activeParam = mbs_pkg::mbs_param_s'(outVec_r);
	assign activeBank = stopSel_r;
	assign liveBank = liveReq | stopSel_r;

	// Register writes. The status word is read-only and answers SLVERR.
	// A write to an unmapped or misaligned address changes nothing.
	// A new terminal function takes effect at once; a stop-gated
	// selection that depends on it settles on the next stopped cycle.
	always_comb begin
		int ti;
		int b1;
		int b2;
		logic [31:0] m;
		ti = winIndex(s_axi_awaddr, mbs_pkg::ADDR_TERM, NTERM);
		b1 = winIndex(s_axi_awaddr, mbs_pkg::ADDR_BANK1, NPAR);
		b2 = winIndex(s_axi_awaddr, mbs_pkg::ADDR_BANK2, NPAR);
		m = '0;
		termFunc_nxt = termFunc_r;
		bank_nxt = bank_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (clkEn && bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (wrGo) begin
			bvalid_nxt = 1'b1;
			bresp_nxt = mbs_pkg::RESP_OKAY;
			if (ti >= 0) begin
				m = laneMerge({24'h000000, termFunc_r[ti]},
					s_axi_wdata, s_axi_wstrb);
				termFunc_nxt[ti] = m[7:0];
			end else if (b1 >= 0) begin
				m = laneMerge(32'(bank_r[0][b1]),
					s_axi_wdata, s_axi_wstrb);
				bank_nxt[0][b1] = m[PW-1:0];
			end else if (b2 >= 0) begin
				m = laneMerge(32'(bank_r[1][b2]),
					s_axi_wdata, s_axi_wstrb);
				bank_nxt[1][b2] = m[PW-1:0];
			end else begin
				bresp_nxt = mbs_pkg::RESP_SLVERR;
			end
		end
	end

	// Register file and write response; functions reset to no function,
	// so no terminal steers a bank until software assigns one.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int t = 0; t < NTERM; t++) begin
				termFunc_r[t] <= mbs_pkg::FN_RST;
			end
			for (int k = 0; k < 2; k++) begin
				for (int p = 0; p < NPAR; p++) begin
					bank_r[k][p] <= mbs_pkg::PAR_RST;
				end
			end
			bvalid_r <= 1'b0;
			bresp_r <= mbs_pkg::RESP_OKAY;
		end else begin
			termFunc_r <= termFunc_nxt;
			bank_r <= bank_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	// Register reads. Unmapped addresses return zero with SLVERR.
	// The status word is assembled at the edge the read is taken.
	always_comb begin
		int ti;
		int b1;
		int b2;
		ti = winIndex(s_axi_araddr, mbs_pkg::ADDR_TERM, NTERM);
		b1 = winIndex(s_axi_araddr, mbs_pkg::ADDR_BANK1, NPAR);
		b2 = winIndex(s_axi_araddr, mbs_pkg::ADDR_BANK2, NPAR);
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (clkEn && rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (rdGo) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = '0;
			rresp_nxt = mbs_pkg::RESP_OKAY;
			if (ti >= 0) begin
				rdata_nxt[7:0] = termFunc_r[ti];
			end else if (b1 >= 0) begin
				rdata_nxt[PW-1:0] = bank_r[0][b1];
			end else if (b2 >= 0) begin
				rdata_nxt[PW-1:0] = bank_r[1][b2];
			end else if (s_axi_araddr == mbs_pkg::ADDR_STATUS) begin
				rdata_nxt[mbs_pkg::ST_ACTIVE] = stopSel_r;
				rdata_nxt[mbs_pkg::ST_LIVE] = liveReq | stopSel_r;
				rdata_nxt[mbs_pkg::ST_STOPPED] = driveStopped;
				rdata_nxt[mbs_pkg::ST_TERM +: NTERM] = termIn;
			end else begin
				rresp_nxt = mbs_pkg::RESP_SLVERR;
			end
		end
	end

	// Read response registers; the data stand until the master takes
	// them, so a slow master never sees them change under it.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= mbs_pkg::RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end
endmodule

// *** bench/mbs_bank_select_asserts.sv ***
`timescale 1ns/1ps
// Port-level checks of bank selection and the bus handshake.
module mbs_bank_select_asserts #(
	parameter int NTERM = 5
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic [NTERM-1:0] termIn,
	input wire logic driveStopped,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input mbs_pkg::mbs_param_s activeParam,
	input wire logic activeBank,
	input wire logic liveBank
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// A whole write offered while the response slot is free.
	sequence wOffer;
		clkEn && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	endsequence
	// The answer follows one edge later.
	sequence wAnswer;
		s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
	endsequence
	AST_HOLD: assert property (
		clkEn && !driveStopped |=> $stable(activeBank))
		else $error("bank moved while running");
	AST_IDLE: assert property (
		clkEn && driveStopped && termIn == '0 |=> !activeBank)
		else $error("first bank not restored");
	AST_SET: assert property (
		$rose(activeBank) |-> $past(driveStopped) && $past(termIn) != '0)
		else $error("second bank without a request");
	AST_LIVE: assert property (
		liveBank && !activeBank |-> termIn != '0)
		else $error("live subset on second bank without a terminal");
	AST_NOLIVE: assert property (
		termIn == '0 |-> liveBank == activeBank)
		else $error("live subset moved with no terminal");
	// Base frequency may only follow the stop-gated bank.
	AST_BASE: assert property (
		$stable(activeBank) && $past(clkEn) && !$past(s_axi_awvalid)
		|=> $stable(activeParam.baseFreq))
		else $error("base frequency changed by live switch");
	AST_WRITE: assert property (wOffer |-> wAnswer)
		else $error("write not answered");
	AST_READ: assert property (
		clkEn && s_axi_arvalid && !s_axi_rvalid
		|-> s_axi_arready ##1 s_axi_rvalid)
		else $error("read not answered");
endmodule

// *** bench/mbs_term_model.sv ***
`timescale 1ns/1ps
// Switch panel stand-in; levels settle one edge after being asked for.
module mbs_term_model (
	input wire logic sys_clk,
	input wire logic [4:0] wantTerm,
	input wire logic wantStop,
	output logic [4:0] termIn,
	output logic driveStopped
);
	// Starts stopped with all terminals off, like a panel at power-up.
	initial begin
		termIn = '0;
		driveStopped = 1'b1;
	end
	// Any terminal may carry the request.
	always @(posedge sys_clk) begin
		termIn <= wantTerm;
		driveStopped <= wantStop;
	end
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] wantTerm = '0;
	logic wantStop = 1'b1;
	logic [4:0] termIn;
	logic stopped, awready, wready, bvalid, arready, rvalid, ab, lb;
	logic aw = 0, wv = 0, bready = 0, ar = 0, rready = 0;
	logic [7:0] addr = '0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	mbs_pkg::mbs_param_s ap;
	logic [15:0] bk[2][6];
	logic [95:0] ex;
	logic mAct = 1'b0;
	logic ce = 1'b1;
	logic [3:0] strb = 4'hf;
	logic [7:0] ba = '0;
	integer seed = 32'hbe8dc7bc;
	int miscompares = 0, n_checks = 0, t1, t2, k;
	mbs_term_model mbs_term_model_inst (.sys_clk(sys_clk),
		.wantTerm(wantTerm), .wantStop(wantStop), .termIn(termIn),
		.driveStopped(stopped));
	mbs_bank_select mbs_bank_select_inst (.sys_clk(sys_clk),
		.arst_n(arst_n), .clkEn(ce), .termIn(termIn),
		.driveStopped(stopped), .s_axi_awaddr(addr), .s_axi_awvalid(aw),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
		.s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(addr),
		.s_axi_arvalid(ar), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.activeParam(ap), .activeBank(ab), .liveBank(lb));
	// Free-running system clock.
	initial begin
		forever #50 sys_clk = !sys_clk;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic ok);
		n_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("[FAIL] %0t value mismatch", $time);
		end
	endtask
	// A wait that runs out ends the run at once.
	task automatic tmo();
		if (k == 50) begin
			chk(1'b0);
			test_done();
		end
	endtask
	// One access; for a read, d is the expected data.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [1:0] er);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		aw <= w;
		wv <= w;
		ar <= !w;
		bready <= w;
		rready <= !w;
		for (k = 0; k < 50; k++) begin
			@(negedge sys_clk);
			if (w ? awready && wready : arready)
				break;
		end
		tmo();
		@(posedge sys_clk);
		aw <= 1'b0;
		wv <= 1'b0;
		ar <= 1'b0;
		for (k = 0; k < 50; k++) begin
			@(negedge sys_clk);
			if (w ? bvalid : rvalid)
				break;
		end
		tmo();
		chk((w ? bresp : rresp) === er);
		if (!w)
			chk(rdata === d);
		@(posedge sys_clk);
		bready <= 1'b0;
		rready <= 1'b0;
	endtask
	// Main sequence: map checks, then random terminal traffic.
	initial begin
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		bus(0, mbs_pkg::ADDR_TERM, 32'h0, mbs_pkg::RESP_OKAY);
		bus(0, 8'h60, 32'h0, mbs_pkg::RESP_SLVERR);
		bus(1, mbs_pkg::ADDR_STATUS, 32'h1, mbs_pkg::RESP_SLVERR);
		for (int i = 0; i < 12; i++) begin
			bk[i/6][i%6] = 16'($random(seed));
			ba = i < 6 ? mbs_pkg::ADDR_BANK1 : mbs_pkg::ADDR_BANK2;
			ba = ba + 8'(4 * (i % 6));
			bus(1, ba, {16'h0, bk[i/6][i%6]}, mbs_pkg::RESP_OKAY);
			bus(0, ba, {16'h0, bk[i/6][i%6]}, mbs_pkg::RESP_OKAY);
		end
		// Byte lanes: a low-byte strobe keeps the upper byte of the word.
		t1 = $random(seed);
		bk[0][0][7:0] = 8'(t1);
		strb <= 4'h1;
		bus(1, mbs_pkg::ADDR_BANK1, 32'(t1), mbs_pkg::RESP_OKAY);
		strb <= 4'hf;
		bus(0, mbs_pkg::ADDR_BANK1, {16'h0, bk[0][0]}, mbs_pkg::RESP_OKAY);
		for (int r = 0; r < 4; r++) begin
			t1 = $unsigned($random(seed)) % 5;
			t2 = (t1 + 1 + $unsigned($random(seed)) % 4) % 5;
			for (int j = 0; j < 5; j++)
				bus(1, mbs_pkg::ADDR_TERM + 8'(4 * j), j == t1 ?
					32'(mbs_pkg::FN_SECOND_MOTOR) : j == t2 ?
					32'(mbs_pkg::FN_LIVE_SWITCH) : 32'(mbs_pkg::FN_RST),
					mbs_pkg::RESP_OKAY);
			if (wantStop)
				mAct = wantTerm[t1];
			for (int s = 0; s < 12; s++) begin
				@(posedge sys_clk);
				wantTerm <= 5'($random(seed));
				wantStop <= 1'($random(seed));
				repeat (4) @(posedge sys_clk);
				@(negedge sys_clk);
				if (wantStop)
					mAct = wantTerm[t1];
				for (int i = 0; i < 6; i++)
					ex[16*i +: 16] = bk[mbs_pkg::LIVE_MASK[i] ?
						wantTerm[t2] | mAct : mAct][i];
				chk(ab === mAct);
				chk(lb === (wantTerm[t2] | mAct));
				chk(ap === ex);
				bus(0, mbs_pkg::ADDR_STATUS, {19'h0, wantTerm, 5'h0,
					wantStop, wantTerm[t2] | mAct, mAct}, mbs_pkg::RESP_OKAY);
			end
		end
		// Clock enable low: a stopped drive must not move the latch.
		@(posedge sys_clk);
		ce <= 1'b0;
		wantStop <= 1'b1;
		wantTerm <= mAct ? 5'h00 : 5'h1f;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(ab === mAct);
		@(posedge sys_clk);
		ce <= 1'b1;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		mAct = wantTerm[t1];
		chk(ab === mAct);
		chk(lb === (wantTerm[t2] | mAct));
		test_done();
	end
endmodule
bind mbs_bank_select mbs_bank_select_asserts #(.NTERM(NTERM)) mbs_chk (
	.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .termIn(termIn),
	.driveStopped(driveStopped), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .activeParam(activeParam),
	.activeBank(activeBank), .liveBank(liveBank));
